// ==== test_packet_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_packet_generator #(
  parameter logic [24:0] BURST_FRAMES = test_packet_generator_pkg::BURST_FRAMES,
  parameter logic [13:0] BLOCK_FRAMES = test_packet_generator_pkg::BLOCK_FRAMES,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic crc_error,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready
);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam logic [7:0] CONTROL_ADDR = {test_packet_generator_pkg::CONTROL_IDX, 2'b00};
  localparam logic [7:0] PATTERN_ADDR = {test_packet_generator_pkg::PATTERN_IDX, 2'b00};
  localparam logic [7:0] CRC_COUNT_ADDR = {test_packet_generator_pkg::CRC_COUNT_IDX, 2'b00};
  localparam logic [7:0] STATUS_ADDR = {test_packet_generator_pkg::STATUS_IDX, 2'b00};

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ test_packet_generator_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // =====================================================
  // AHB-Lite slave, zero wait states
  logic [15:0] control;
  logic [15:0] pattern;
  logic [7:0] crc_count;
  logic [7:0] wr_addr;
  logic wr_pend;
  logic [31:0] rdata;
  logic active;
  logic burst_done;

  wire addr_phase = hsel & htrans[1] & hready;
  wire addr_in_map = (haddr[31:8] == 24'h000000);
  wire wr_take = addr_phase & hwrite & (hsize == 3'h2);
  wire rd_take = addr_phase & ~hwrite;
  wire cnt_clear = rd_take & addr_in_map & (haddr[7:0] == CRC_COUNT_ADDR);
  wire [15:0] status_word = {14'h0000, burst_done, active};
  wire [15:0] read_mux = ~addr_in_map ? 16'h0000 :
                         (haddr[7:0] == CONTROL_ADDR) ? control :
                         (haddr[7:0] == PATTERN_ADDR) ? pattern :
                         (haddr[7:0] == CRC_COUNT_ADDR) ? {8'h00, crc_count} :
                         (haddr[7:0] == STATUS_ADDR) ? status_word : 16'h0000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rdata <= 32'h00000000;
    end else begin
      wr_pend <= wr_take & addr_in_map;
      wr_addr <= haddr[7:0];
      if (rd_take) begin
        rdata <= {16'h0000, read_mux};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control <= test_packet_generator_pkg::CONTROL_RESET;
      pattern <= test_packet_generator_pkg::PATTERN_RESET;
    end else if (wr_pend) begin
      if (wr_addr == CONTROL_ADDR) begin
        control <= hwdata[15:0];
      end
      if (wr_addr == PATTERN_ADDR) begin
        pattern <= hwdata[15:0];
      end
    end
  end

  // a count that lands in the clearing read cycle survives as one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_count <= 8'h00;
    end else if (cnt_clear) begin
      crc_count <= {7'h00, crc_error};
    end else if (crc_error && crc_count != 8'hFF) begin
      crc_count <= crc_count + 8'h01;
    end
  end

  // =====================================================
  // run control and settings snapshot
  test_packet_generator_pkg::gen_state_type state;
  test_packet_generator_pkg::gen_state_type next_state;
  logic go_q;
  logic restart_req;
  logic [13:0] idx;
  logic [10:0] gap_cnt;
  logic [24:0] frame_cnt;
  logic [13:0] blk_cnt;
  logic [31:0] crc;
  logic [15:0] lfsr;
  logic cfg_cont;
  logic [1:0] cfg_len;
  logic cfg_gap;
  logic [3:0] cfg_da;
  logic [3:0] cfg_sa;
  logic cfg_random;
  logic cfg_bad;
  logic [15:0] cfg_pat;
  logic fifo_in_ready;

  wire go = control[test_packet_generator_pkg::BIT_ENABLE] & control[test_packet_generator_pkg::BIT_RUN];
  wire go_rise = go & ~go_q;
  wire at_boundary = (state == test_packet_generator_pkg::ST_IDLE) |
                     ((state == test_packet_generator_pkg::ST_GAP) && (gap_cnt == 11'h000));
  wire take = at_boundary & restart_req & go;
  wire burst_end = ~cfg_cont & (frame_cnt == BURST_FRAMES);
  wire cont_end = cfg_cont & ~control[test_packet_generator_pkg::BIT_CONT] & (blk_cnt == 14'h0000);
  wire stop_now = ~go | burst_end | cont_end;
  wire start_frame = at_boundary & (take | (active & ~stop_now));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_q <= 1'b0;
      restart_req <= 1'b0;
      active <= 1'b0;
      burst_done <= 1'b0;
    end else begin
      go_q <= go;
      restart_req <= go_rise | (restart_req & ~take);
      active <= take | (active & ~(at_boundary & stop_now));
      burst_done <= ~take & (burst_done | (at_boundary & active & burst_end));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cfg_cont, cfg_len, cfg_gap, cfg_da, cfg_sa, cfg_random, cfg_bad} <= 14'h0000;
      cfg_pat <= 16'h0000;
    end else if (take) begin
      {cfg_cont, cfg_len, cfg_gap, cfg_da, cfg_sa, cfg_random, cfg_bad} <= control[13:0];
      cfg_pat <= pattern;
    end
  end

  // =====================================================
  // byte generator
  wire [13:0] len_bytes = (cfg_len == 2'b00) ? test_packet_generator_pkg::LEN_125 :
                          (cfg_len == 2'b01) ? test_packet_generator_pkg::LEN_64 :
                          (cfg_len == 2'b10) ? test_packet_generator_pkg::LEN_1518 :
                          test_packet_generator_pkg::LEN_JUMBO;
  wire [13:0] seg_last = (state == test_packet_generator_pkg::ST_PRE) ? test_packet_generator_pkg::PRE_LAST :
                         (state == test_packet_generator_pkg::ST_HDR) ? test_packet_generator_pkg::HDR_LAST :
                         (state == test_packet_generator_pkg::ST_PAY) ?
                         (len_bytes - test_packet_generator_pkg::NON_PAYLOAD_LAST) :
                         test_packet_generator_pkg::FCS_LAST;
  wire seg_end = (idx == seg_last);
  wire gen_valid = (state == test_packet_generator_pkg::ST_PRE) | (state == test_packet_generator_pkg::ST_HDR) |
                   (state == test_packet_generator_pkg::ST_PAY) | (state == test_packet_generator_pkg::ST_FCS);
  wire push = gen_valid & fifo_in_ready;
  wire gen_last = (state == test_packet_generator_pkg::ST_FCS) & seg_end;
  wire frame_done = push & gen_last;
  wire [31:0] fcs = ~crc ^ {31'h00000000, cfg_bad};
  wire [7:0] pre_byte = (idx == test_packet_generator_pkg::PRE_LAST) ? test_packet_generator_pkg::SFD_BYTE :
                        test_packet_generator_pkg::PREAMBLE_BYTE;
  wire [7:0] hdr_byte = (idx == 14'h0005) ? {4'hF, cfg_da} :
                        (idx == 14'h000B) ? {4'hF, cfg_sa} :
                        (idx == 14'h000C) ? test_packet_generator_pkg::ETHER_TYPE[15:8] :
                        (idx == 14'h000D) ? test_packet_generator_pkg::ETHER_TYPE[7:0] : 8'hFF;
  wire [7:0] pay_byte = cfg_random ? lfsr[7:0] : (idx[0] ? cfg_pat[7:0] : cfg_pat[15:8]);
  wire [7:0] gen_byte = (state == test_packet_generator_pkg::ST_PRE) ? pre_byte :
                        (state == test_packet_generator_pkg::ST_HDR) ? hdr_byte :
                        (state == test_packet_generator_pkg::ST_PAY) ? pay_byte :
                        fcs[{idx[1:0], 3'b000} +: 8];
  wire crc_feed = push & ((state == test_packet_generator_pkg::ST_HDR) | (state == test_packet_generator_pkg::ST_PAY));
  wire [10:0] gap_load = cfg_gap ? 11'(test_packet_generator_pkg::GAP_LONG_CYC - 1) :
                         11'(test_packet_generator_pkg::GAP_SHORT_CYC - 1);

  always_comb begin
    next_state = state;
    case (state)
      test_packet_generator_pkg::ST_IDLE: begin
        if (start_frame) next_state = test_packet_generator_pkg::ST_PRE;
      end
      test_packet_generator_pkg::ST_PRE: begin
        if (push && seg_end) next_state = test_packet_generator_pkg::ST_HDR;
      end
      test_packet_generator_pkg::ST_HDR: begin
        if (push && seg_end) next_state = test_packet_generator_pkg::ST_PAY;
      end
      test_packet_generator_pkg::ST_PAY: begin
        if (push && seg_end) next_state = test_packet_generator_pkg::ST_FCS;
      end
      test_packet_generator_pkg::ST_FCS: begin
        if (push && seg_end) next_state = test_packet_generator_pkg::ST_GAP;
      end
      test_packet_generator_pkg::ST_GAP: begin
        if (gap_cnt == 11'h000) begin
          next_state = start_frame ? test_packet_generator_pkg::ST_PRE : test_packet_generator_pkg::ST_IDLE;
        end
      end
      default: next_state = test_packet_generator_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= test_packet_generator_pkg::ST_IDLE;
      idx <= 14'h0000;
      gap_cnt <= 11'h000;
    end else begin
      state <= next_state;
      idx <= (start_frame || (push && seg_end)) ? 14'h0000 : (push ? idx + 14'h0001 : idx);
      gap_cnt <= frame_done ? gap_load : ((gap_cnt != 11'h000) ? gap_cnt - 11'h001 : gap_cnt);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc <= test_packet_generator_pkg::CRC_INIT;
      lfsr <= test_packet_generator_pkg::LFSR_SEED;
    end else begin
      if (start_frame) begin
        crc <= test_packet_generator_pkg::CRC_INIT;
      end else if (crc_feed) begin
        crc <= crc_step(crc, gen_byte);
      end
      if (take) begin
        lfsr <= test_packet_generator_pkg::LFSR_SEED;
      end else if (push && state == test_packet_generator_pkg::ST_PAY) begin
        lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? 16'hB400 : 16'h0000);
      end
    end
  end

  // frame_cnt only grows in burst mode so it cannot wrap there
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_cnt <= 25'h0000000;
      blk_cnt <= 14'h0000;
    end else if (take) begin
      frame_cnt <= 25'h0000000;
      blk_cnt <= 14'h0000;
    end else if (frame_done) begin
      frame_cnt <= cfg_cont ? frame_cnt : frame_cnt + 25'h0000001;
      blk_cnt <= (blk_cnt == BLOCK_FRAMES - 14'h0001) ? 14'h0000 : blk_cnt + 14'h0001;
    end
  end

  // =====================================================
  // output buffer: a stalled receiver freezes the generator, no byte lost
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fill;
  logic [8:0] fifo_q [FIFO_DEPTH];

  wire pop = tx_valid & tx_ready;
  assign fifo_in_ready = (fill != (PW + 1)'(FIFO_DEPTH));
  assign tx_valid = (fill != '0);
  assign tx_data = fifo_q[rd_ptr][7:0];
  assign tx_last = fifo_q[rd_ptr][8];

  for (genvar e = 0; e < FIFO_DEPTH; e++) begin : g_slot
    logic [8:0] slot;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        slot <= 9'h000;
      end else if (push && wr_ptr == PW'(e)) begin
        slot <= {gen_last, gen_byte};
      end
    end
    assign fifo_q[e] = slot;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      if (pop) rd_ptr <= (rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      fill <= fill + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence frame_end_s;
    push && state == test_packet_generator_pkg::ST_FCS && seg_end;
  endsequence

  sequence header_end_s;
    push && state == test_packet_generator_pkg::ST_HDR && seg_end;
  endsequence

  AST_IDLE_WITHOUT_GO: assert property ((state == test_packet_generator_pkg::ST_IDLE && !go) |=>
    state == test_packet_generator_pkg::ST_IDLE) else $error("generator left idle without enable and run");
  AST_GAP_LENGTH: assert property (frame_end_s |=>
    (state == test_packet_generator_pkg::ST_GAP && gap_cnt == gap_load)) else $error("wrong gap load");
  AST_PAYLOAD_AFTER_HEADER: assert property (header_end_s |=>
    (state == test_packet_generator_pkg::ST_PAY && idx == 14'h0000)) else $error("payload not after header");
  AST_DEST_NIBBLE: assert property ((push && idx == 14'h0005 &&
    state == test_packet_generator_pkg::ST_HDR) |-> gen_byte == {4'hF, cfg_da}) else $error("bad destination byte");
  AST_SRC_NIBBLE: assert property ((push && idx == 14'h000B &&
    state == test_packet_generator_pkg::ST_HDR) |-> gen_byte == {4'hF, cfg_sa}) else $error("bad source byte");
  AST_FIXED_PAYLOAD: assert property ((push && !cfg_random &&
    state == test_packet_generator_pkg::ST_PAY) |-> gen_byte == (idx[0] ? cfg_pat[7:0] : cfg_pat[15:8]))
    else $error("fixed payload mismatch");
  AST_FCS_FIRST: assert property ((push && idx == 14'h0000 &&
    state == test_packet_generator_pkg::ST_FCS) |-> gen_byte == (~crc[7:0] ^ {7'h00, cfg_bad}))
    else $error("first FCS byte wrong");
  AST_CRC_SATURATES: assert property ((crc_count == 8'hFF && !cnt_clear) |=> crc_count == 8'hFF)
    else $error("crc counter wrapped");
  AST_BURST_LIMIT: assert property ((active && !cfg_cont) |-> frame_cnt <= BURST_FRAMES)
    else $error("burst overran");
  AST_SETTINGS_HELD: assert property ((active && !take) |=> $stable(cfg_pat) && $stable(cfg_len))
    else $error("settings changed while running");
  AST_PREAMBLE: assert property ((push && state == test_packet_generator_pkg::ST_PRE) |->
    gen_byte == (idx == 14'h0007 ? 8'hD5 : 8'h55)) else $error("bad preamble byte");
endmodule
`default_nettype wire

// ==== test_packet_generator_pkg.sv ====
`default_nettype none
package test_packet_generator_pkg;
  // =====================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned GAP_SHORT_NS = 96;
  localparam int unsigned GAP_LONG_NS = 8192;
  localparam int unsigned GAP_SHORT_CYC = (GAP_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GAP_LONG_CYC = (GAP_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // =====================================================
  // register map: index times four is the byte address
  localparam logic [5:0] CRC_COUNT_IDX = 6'h17;
  localparam logic [5:0] CONTROL_IDX = 6'h1D;
  localparam logic [5:0] PATTERN_IDX = 6'h1E;
  localparam logic [5:0] STATUS_IDX = 6'h20;
  localparam logic [15:0] CONTROL_RESET = 16'h0040;
  localparam logic [15:0] PATTERN_RESET = 16'h0000;
  localparam int unsigned BIT_ENABLE = 15;
  localparam int unsigned BIT_RUN = 14;
  localparam int unsigned BIT_CONT = 13;
  localparam int unsigned LEN_LSB = 11;
  localparam int unsigned BIT_GAP = 10;
  localparam int unsigned DA_LSB = 6;
  localparam int unsigned SA_LSB = 2;
  localparam int unsigned BIT_RANDOM = 1;
  localparam int unsigned BIT_BAD_FCS = 0;
  // =====================================================
  // frame layout
  localparam logic [13:0] LEN_125 = 14'h007D;
  localparam logic [13:0] LEN_64 = 14'h0040;
  localparam logic [13:0] LEN_1518 = 14'h05EE;
  localparam logic [13:0] LEN_JUMBO = 14'h2710;
  localparam logic [13:0] NON_PAYLOAD_LAST = 14'h0013;
  localparam logic [13:0] PRE_LAST = 14'h0007;
  localparam logic [13:0] HDR_LAST = 14'h000D;
  localparam logic [13:0] FCS_LAST = 14'h0003;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [15:0] ETHER_TYPE = 16'h88B5;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [24:0] BURST_FRAMES = 25'h1C9C380;
  localparam logic [13:0] BLOCK_FRAMES = 14'h2710;
  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_HDR, ST_PAY, ST_FCS, ST_GAP} gen_state_type;
endpackage
`default_nettype wire

// ==== tx_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tx_sink_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall_en,
  input wire logic [7:0] data,
  input wire logic last,
  input wire logic valid,
  output logic ready
);
  // =====
  // keeps the first 128 bytes of the latest frame; bytes past 128 are only counted
  logic [7:0] frame_buf [0:127];
  logic [2:0] phase;
  int idx, frames, last_len, gap, since;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 3'h0;
      ready <= 1'b0;
      idx <= 0;
      frames <= 0;
      last_len <= 0;
      gap <= 0;
      since <= 0;
    end else begin
      phase <= phase + 3'h1;
      // stalls three of four cycles so the buffer must hold words back
      ready <= !stall_en || (phase[2:1] == 2'b11);
      since <= since + 1;
      if (valid && ready) begin
        if (idx < 128) frame_buf[idx] <= data;
        if (idx == 0) gap <= since;
        idx <= last ? 0 : idx + 1;
        since <= 0;
        if (last) begin
          frames <= frames + 1;
          last_len <= idx + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_test_packet_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_test_packet_generator;
  logic hclk, hresetn, hsel, hwrite, crc_error, stall_en;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hready, hreadyout, hresp, tx_last, tx_valid, tx_ready;
  wire [31:0] hrdata;
  wire [7:0] tx_data;
  int mismatches, checked, base;
  int lens [4] = '{125, 64, 1518, 10000};
  assign hready = hreadyout;
  test_packet_generator #(.BURST_FRAMES(25'h2), .BLOCK_FRAMES(14'h3)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .crc_error(crc_error),
    .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready));
  tx_sink_model sink (.clk(hclk), .rst_n(hresetn), .stall_en(stall_en), .data(tx_data), .last(tx_last),
    .valid(tx_valid), .ready(tx_ready));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // =====
  // shared tasks
  task automatic end_of_test();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic hold();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [15:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    haddr <= {24'h000000, idx, 2'b00};
    hold();
    htrans <= 2'b00;
    hwdata <= {16'h0000, v};
    hold();
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [5:0] idx, input logic [15:0] exp);
    xfer(1'b0, idx, 16'h0000);
    check(rd, {16'h0000, exp});
  endtask
  task automatic restart(input logic [15:0] v);
    // only ever started toward the sink model, never toward live traffic
    xfer(1'b1, test_packet_generator_pkg::CONTROL_IDX, v & 16'hBFFF);
    xfer(1'b1, test_packet_generator_pkg::CONTROL_IDX, v);
  endtask
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (sink.frames < n && k < 60000) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 60000) begin
      mismatches++;
      end_of_test();
    end
  endtask
  function automatic logic [31:0] fcs_of(input int n);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 8; i < 8 + n; i++) begin
      c ^= {24'h000000, sink.frame_buf[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction
  // 64-byte frame seen whole, preamble included; payload bytes skipped when pat is zero
  task automatic frame64(input logic [3:0] da, input logic [3:0] sa, input logic [15:0] pat, input logic bad);
    logic [7:0] e;
    for (int i = 0; i < 68; i++) begin
      e = i < 7 ? 8'h55 : i == 7 ? 8'hD5 : i == 13 ? {4'hF, da} : i == 19 ? {4'hF, sa} : i < 20 ? 8'hFF :
        i == 20 ? 8'h88 : i == 21 ? 8'hB5 : i[0] ? pat[7:0] : pat[15:8];
      if (i < 22 || pat != 16'h0000) check(sink.frame_buf[i], e);
    end
    check({sink.frame_buf[71], sink.frame_buf[70], sink.frame_buf[69], sink.frame_buf[68]},
      fcs_of(60) ^ {31'h0, bad});
    check(sink.last_len, 72);
  endtask
  // =====
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    crc_error = 1'b0;
    stall_en = 1'b1;
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(test_packet_generator_pkg::CONTROL_IDX, 16'h0040);
    rdchk(test_packet_generator_pkg::PATTERN_IDX, 16'h0000);
    rdchk(test_packet_generator_pkg::CRC_COUNT_IDX, 16'h0000);
    xfer(1'b1, 6'h3F, 16'hFFFF);
    rdchk(6'h3F, 16'h0000);
    xfer(1'b1, test_packet_generator_pkg::PATTERN_IDX, 16'hA55A);
    rdchk(test_packet_generator_pkg::PATTERN_IDX, 16'hA55A);
    // burst of two 64-byte frames while the sink stalls
    restart(16'hC8D4);
    wait_frames(2);
    frame64(4'h3, 4'h5, 16'hA55A, 1'b0);
    repeat (400) @(posedge hclk);
    check(sink.frames, 2);
    xfer(1'b0, test_packet_generator_pkg::STATUS_IDX, 16'h0000);
    check(rd[1:0], 2'b10);
    stall_en <= 1'b0;
    restart(16'hC8D5);
    wait_frames(4);
    frame64(4'h3, 4'h5, 16'hA55A, 1'b1);
    check(sink.gap >= 19 && sink.gap <= 30, 1'b1);
    restart(16'hCCD4);
    wait_frames(6);
    check(sink.gap >= 1638 && sink.gap <= 1650, 1'b1);
    for (int c = 0; c < 4; c++) begin
      base = sink.frames;
      restart(16'hC000 | 16'(c << 11));
      wait_frames(base + 2);
      check(sink.last_len, lens[c] + 8);
    end
    // continuous run, pattern changed mid-run, then continuous cleared
    base = sink.frames;
    restart(16'hE8D4);
    wait_frames(base + 1);
    xfer(1'b1, test_packet_generator_pkg::PATTERN_IDX, 16'h1234);
    wait_frames(base + 4);
    frame64(4'h3, 4'h5, 16'hA55A, 1'b0);
    xfer(1'b0, test_packet_generator_pkg::STATUS_IDX, 16'h0000);
    check(rd[0], 1'b1);
    xfer(1'b1, test_packet_generator_pkg::CONTROL_IDX, 16'hC8D4);
    repeat (800) @(posedge hclk);
    check((sink.frames - base) % 3, 0);
    xfer(1'b0, test_packet_generator_pkg::STATUS_IDX, 16'h0000);
    check(rd[0], 1'b0);
    check(sink.last_len, 72);
    restart(16'hC8D4);
    wait_frames(sink.frames + 2);
    frame64(4'h3, 4'h5, 16'h1234, 1'b0);
    // run without enable sends nothing
    base = sink.frames;
    xfer(1'b1, test_packet_generator_pkg::CONTROL_IDX, 16'h08D4);
    xfer(1'b1, test_packet_generator_pkg::CONTROL_IDX, 16'h48D4);
    repeat (400) @(posedge hclk);
    check(sink.frames, base);
    restart(16'hC8D6);
    wait_frames(base + 2);
    frame64(4'h3, 4'h5, 16'h0000, 1'b0);
    check({sink.frame_buf[22], sink.frame_buf[23], sink.frame_buf[24]} != 24'h000000, 1'b1);
    // error counter: exact count, then saturation, then clear on read
    for (int n = 0; n < 2; n++) begin
      @(posedge hclk);
      crc_error <= 1'b1;
      repeat (n ? 260 : 3) @(posedge hclk);
      crc_error <= 1'b0;
      rdchk(test_packet_generator_pkg::CRC_COUNT_IDX, n ? 16'h00FF : 16'h0003);
    end
    rdchk(test_packet_generator_pkg::CRC_COUNT_IDX, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
